/* rtl/rcs_sequencer.sv */
// Contract
// - watchdog expiry without clear resets device
// - watchdog reset: timeout cleared, pc zero
// - run only after timers and pin release
// - disabled powerup timer adds no delay
// - timeouts from power-on; late pin runs immediately
// - power-on: poweron clear, timeout/powerdown set
// - brown-out: brownout clear, timeout/powerdown set
// - pin reset running: flags unchanged, pc zero
// - pin reset asleep: timeout set, powerdown clear
// - watchdog asleep wakes, clears both flags
// - irq wake: timeout set, powerdown clear
// - irq wake with enable: next, then vector
// - power control: two flags, upper bits zero
// - unimplemented status bits read zero
// - status and power flags update together
// - powerup timer holds reset 64 ms
// - timer cfg set disables, clear enables
// - select zero internal, one pin reset
`include "rcs_defines.svh"

module rcs_sequencer #(
  parameter int POWERUP_TIMER_CYCLES = `RCS_POWERUP_TIMER_CYCLES,
  parameter int OST_CYCLES  = `RCS_OST_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        POR_EVENT,
  input  wire logic        BOR_EVENT,
  input  wire logic        EXT_RESET_PIN_N,
  input  wire logic        EXT_RESET_SELECT,
  input  wire logic        POWERUP_TIMER_CFG,
  input  wire logic        WATCHDOG_EXPIRE,
  input  wire logic        WATCHDOG_CLEAR_INSTR,
  input  wire logic        SLEEP_INSTR,
  input  wire logic        IRQ_WAKE,
  input  wire logic        GLOBAL_IRQ_ENABLE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             CORE_RUN,
  output logic             CORE_RESET_N,
  output logic             IRQ
);

  // --------------------------------------------------------------------------
  // pin synchroniser and sequencer state
  // --------------------------------------------------------------------------
  logic             pin_meta_reg;
  logic             pin_sync_reg;
  logic             pin_low;
  rcs_pkg::rcs_state_t state_reg;
  logic [31:0]      cnt_reg;
  logic [12:0]      pc_reg;
  logic             vec_pend_reg;
  logic [7:0]       status_reg;
  logic [1:0]       power_control_flags_reg;
  logic [`RCS_IRQ_W-1:0] irq_stat_reg;
  logic [`RCS_IRQ_W-1:0] irq_en_reg;
  logic [`RCS_IRQ_W-1:0] irq_ev;
  logic             wr_en;
  logic             rd_en;
  logic             mapped;
  logic             wd_reset;
  logic             wd_wake;
  logic             pin_reset_run;
  logic             pin_reset_sleep;
  logic             irq_wakeup;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction : addr_hit

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end
    else
    begin
      pin_meta_reg <= EXT_RESET_PIN_N;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // internal reset when select is zero: pin ignored
  assign pin_low = EXT_RESET_SELECT & ~pin_sync_reg;

  // --------------------------------------------------------------------------
  // reset and wake events
  // --------------------------------------------------------------------------
  wire running  = (state_reg == rcs_pkg::RCS_ST_RUN);
  wire sleeping = (state_reg == rcs_pkg::RCS_ST_SLEEP);
  // clear instruction in the same cycle rescues the core
  assign wd_reset        = running & WATCHDOG_EXPIRE & ~WATCHDOG_CLEAR_INSTR;
  assign wd_wake         = sleeping & WATCHDOG_EXPIRE;
  assign pin_reset_run   = running & pin_low;
  assign pin_reset_sleep = sleeping & pin_low;
  assign irq_wakeup      = sleeping & IRQ_WAKE & ~pin_low & ~WATCHDOG_EXPIRE;

  // --------------------------------------------------------------------------
  // start-up sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= rcs_pkg::RCS_ST_OFF;
      cnt_reg   <= 32'h0000_0000;
    end
    else if (POR_EVENT || BOR_EVENT)
    begin
      // timers restart from the power-on pulse, whatever the pin does
      state_reg <= rcs_pkg::RCS_ST_OFF;
      cnt_reg   <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        rcs_pkg::RCS_ST_OFF:
        begin
          cnt_reg <= 32'h0000_0000;
          if (POWERUP_TIMER_CFG)
            state_reg <= rcs_pkg::RCS_ST_OST;
          else
            state_reg <= rcs_pkg::RCS_ST_POWERUP_TIMER;
        end
        rcs_pkg::RCS_ST_POWERUP_TIMER:
        begin
          if (cnt_reg >= 32'(POWERUP_TIMER_CYCLES - 1))
          begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= rcs_pkg::RCS_ST_OST;
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        rcs_pkg::RCS_ST_OST:
        begin
          if (cnt_reg >= 32'(OST_CYCLES - 1))
          begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= rcs_pkg::RCS_ST_PIN;
          end
          else
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
        rcs_pkg::RCS_ST_PIN:
        begin
          if (!pin_low)
            state_reg <= rcs_pkg::RCS_ST_RUN;
        end
        rcs_pkg::RCS_ST_RUN:
        begin
          // pin and watchdog resets restart without timers
          if (wd_reset || pin_reset_run)
            state_reg <= rcs_pkg::RCS_ST_PIN;
          else if (SLEEP_INSTR)
            state_reg <= rcs_pkg::RCS_ST_SLEEP;
        end
        rcs_pkg::RCS_ST_SLEEP:
        begin
          if (pin_reset_sleep)
            state_reg <= rcs_pkg::RCS_ST_PIN;
          else if (wd_wake || irq_wakeup)
            state_reg <= rcs_pkg::RCS_ST_RUN;
        end
        default:
          state_reg <= rcs_pkg::RCS_ST_OFF;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // program counter: zero on resets, +1 on wake, vector after irq wake with global enable
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pc_reg       <= `RCS_PC_RESET;
      vec_pend_reg <= 1'b0;
    end
    else if (POR_EVENT || BOR_EVENT || wd_reset || pin_reset_run || pin_reset_sleep)
    begin
      pc_reg       <= `RCS_PC_RESET;
      vec_pend_reg <= 1'b0;
    end
    else if (wd_wake || irq_wakeup)
    begin
      pc_reg       <= pc_reg + 13'h0001;
      vec_pend_reg <= irq_wakeup & GLOBAL_IRQ_ENABLE;
    end
    else if (vec_pend_reg && running)
    begin
      // next instruction has executed; now take the vector
      pc_reg       <= `RCS_PC_IRQ_VEC;
      vec_pend_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // apb slave, one wait state
  // --------------------------------------------------------------------------
  // write lands only at the edge where the master sees ready
  assign wr_en  = PSEL & PENABLE & PWRITE & PREADY;
  assign rd_en  = PSEL & PENABLE & ~PWRITE;
  assign mapped = addr_hit(PADDR, `RCS_ADDR_PWRCTL) | addr_hit(PADDR, `RCS_ADDR_STATUS)
                | addr_hit(PADDR, `RCS_ADDR_CTRL) | addr_hit(PADDR, `RCS_ADDR_IRQ_STAT)
                | addr_hit(PADDR, `RCS_ADDR_IRQ_EN) | addr_hit(PADDR, `RCS_ADDR_IRQ_CLR)
                | addr_hit(PADDR, `RCS_ADDR_PC);

  // --------------------------------------------------------------------------
  // status and power control flags, updated in the same edge
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      status_reg <= 8'h18;
      power_control_flags_reg   <= 2'h0;
    end
    else if (POR_EVENT)
    begin
      status_reg <= 8'h18;
      power_control_flags_reg[`RCS_POWER_CONTROL_FLAGS_POR_BIT] <= 1'b0;
    end
    else if (BOR_EVENT)
    begin
      status_reg <= 8'h18;
      power_control_flags_reg[`RCS_POWER_CONTROL_FLAGS_BOR_BIT] <= 1'b0;
    end
    else if (wd_reset)
      status_reg <= {4'h0, status_reg[3:0]};
    else if (pin_reset_run)
      status_reg <= {3'h0, status_reg[4:0]};
    else if (pin_reset_sleep)
      status_reg <= {4'h1, 1'b0, status_reg[2:0]};
    else if (wd_wake)
      status_reg <= {status_reg[7:5], 2'b00, status_reg[2:0]};
    else if (irq_wakeup)
      status_reg <= {status_reg[7:5], 2'b10, status_reg[2:0]};
    else if (wr_en && addr_hit(PADDR, `RCS_ADDR_PWRCTL))
      power_control_flags_reg <= PWDATA[1:0];
    else if (wr_en && addr_hit(PADDR, `RCS_ADDR_STATUS))
      // timeout and powerdown are hardware owned
      status_reg <= {PWDATA[7:5], status_reg[4:3], PWDATA[2:0]};
  end

  // --------------------------------------------------------------------------
  // sticky events; set wins over clear
  // --------------------------------------------------------------------------
  assign irq_ev = {irq_wakeup, wd_wake, pin_reset_run | pin_reset_sleep, wd_reset, BOR_EVENT, POR_EVENT};

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
    end
    else
    begin
      if (wr_en && addr_hit(PADDR, `RCS_ADDR_IRQ_EN))
        irq_en_reg <= PWDATA[`RCS_IRQ_W-1:0];
      if (wr_en && addr_hit(PADDR, `RCS_ADDR_IRQ_CLR))
        irq_stat_reg <= (irq_stat_reg & ~PWDATA[`RCS_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      // ready is a registered pulse: one wait state per access
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      PRDATA  <= 32'h0000_0000;
      if (rd_en && !PREADY)
      begin
        case (PADDR)
          `RCS_ADDR_PWRCTL:   PRDATA <= {30'h0, power_control_flags_reg};
          `RCS_ADDR_STATUS:   PRDATA <= {24'h0, status_reg};
          `RCS_ADDR_CTRL:     PRDATA <= {29'h0, state_reg};
          `RCS_ADDR_IRQ_STAT: PRDATA <= {26'h0, irq_stat_reg};
          `RCS_ADDR_IRQ_EN:   PRDATA <= {26'h0, irq_en_reg};
          `RCS_ADDR_PC:       PRDATA <= {19'h0, pc_reg};
          default:            PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CORE_RUN     <= 1'b0;
      CORE_RESET_N <= 1'b0;
      IRQ          <= 1'b0;
    end
    else
    begin
      CORE_RUN     <= running;
      CORE_RESET_N <= running | sleeping;
      IRQ          <= |(irq_stat_reg & irq_en_reg);
    end
  end

endmodule : rcs_sequencer

/* rtl/rcs_defines.svh */
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define RCS_ADDR_PWRCTL     12'h238
`define RCS_POWER_CONTROL_FLAGS_INDEX      8'h8E
`define RCS_ADDR_STATUS     12'h000
`define RCS_ADDR_CTRL       12'h004
`define RCS_ADDR_IRQ_STAT   12'h008
`define RCS_ADDR_IRQ_EN     12'h00C
`define RCS_ADDR_IRQ_CLR    12'h010
`define RCS_ADDR_PC         12'h014

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RCS_POWER_CONTROL_FLAGS_POR_BIT    1
`define RCS_POWER_CONTROL_FLAGS_BOR_BIT    0
`define RCS_ST_TO_BIT       4
`define RCS_ST_PD_BIT       3
`define RCS_CTRL_RUN_BIT    0
`define RCS_CTRL_SLEEP_BIT  1
`define RCS_CTRL_STAT_BIT   2
`define RCS_IRQ_W           6

// ----------------------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------------------
`define RCS_PC_RESET        13'h0000
`define RCS_PC_IRQ_VEC      13'h0004
`define RCS_ST_STATUS_MASK  8'hFF
`define RCS_POWER_CONTROL_FLAGS_MASK       8'h03

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RCS_CLK_MHZ         100
`define RCS_POWERUP_TIMER_MS         64
`define RCS_POWERUP_TIMER_CYCLES     (`RCS_POWERUP_TIMER_MS * 1000 * `RCS_CLK_MHZ)
`define RCS_OST_CYCLES      1024

`endif

/* rtl/rcs_pkg.sv */
package rcs_pkg;
  typedef enum logic [2:0]
  {
    RCS_ST_OFF   = 3'h0,
    RCS_ST_POWERUP_TIMER  = 3'h1,
    RCS_ST_OST   = 3'h3,
    RCS_ST_PIN   = 3'h2,
    RCS_ST_RUN   = 3'h6,
    RCS_ST_SLEEP = 3'h7
  } rcs_state_t;
endpackage : rcs_pkg

/* verif/rcs_sequencer_sva.sv */
module rcs_chk (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        POR_EVENT,
  input wire logic        BOR_EVENT,
  input wire logic        EXT_RESET_PIN_N,
  input wire logic        EXT_RESET_SELECT,
  input wire logic        WATCHDOG_EXPIRE,
  input wire logic        WATCHDOG_CLEAR_INSTR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CORE_RUN,
  input wire logic        CORE_RESET_N
);
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_rdy_pulse; PREADY |=> !PREADY; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
  property p_rdy_follow; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_rdy_follow: assert property (p_rdy_follow) else $error("ready late");
  property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_slverr; PREADY |-> PSLVERR == !(PADDR inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
    12'h014, 12'h238}); endproperty
  a_slverr: assert property (p_slverr) else $error("error response wrong");
  // two cycles of slack: run output lags the state by one register
  property p_wd_reset; CORE_RUN && WATCHDOG_EXPIRE && !WATCHDOG_CLEAR_INSTR |-> ##[1:3] !CORE_RUN; endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("no watchdog reset");
  property p_por_hold; POR_EVENT |-> ##2 !CORE_RUN [*8]; endproperty
  a_por_hold: assert property (p_por_hold) else $error("ran during start-up");
  property p_pin_hold; (EXT_RESET_SELECT && !EXT_RESET_PIN_N) [*6] |-> !CORE_RUN; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low but running");
  property p_run_pin; $rose(CORE_RUN) |-> !EXT_RESET_SELECT || $past(EXT_RESET_PIN_N, 3); endproperty
  a_run_pin: assert property (p_run_pin) else $error("ran before pin release");
  property p_sleep_wd; CORE_RESET_N && !CORE_RUN && WATCHDOG_EXPIRE && !POR_EVENT && !BOR_EVENT
    |=> CORE_RESET_N; endproperty
  a_sleep_wd: assert property (p_sleep_wd) else $error("watchdog reset in sleep");
endmodule : rcs_chk

bind rcs_sequencer rcs_chk u_chk (.*);

/* verif/rcs_supply_model.sv */
module rcs_supply_model (
  input  wire logic clk,
  output logic      por_event,
  output logic      bor_event,
  output logic      ext_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // supply monitors and reset pin
  // --------------------------------------------------------------
  // pin rests high: the model drives it high from time zero until the pin task changes it
  initial
  begin
    por_event       = 1'b0;
    bor_event       = 1'b0;
    ext_reset_pin_n = 1'b1;
  end

  task automatic supply(input logic brown);
    @(posedge clk);
    por_event <= !brown;
    bor_event <= brown;
    @(posedge clk);
    por_event <= 1'b0;
    bor_event <= 1'b0;
  endtask : supply

  task automatic pin(input logic level);
    @(posedge clk);
    ext_reset_pin_n <= level;
  endtask : pin
endmodule : rcs_supply_model

/* verif/tb_top.sv */
`include "rcs_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POWERUP_TIMER = 20;
  logic        clk, rst_n, sel, cfg, global_irq_enable, psel, penable, pwrite, pready, err, se, run, crst_n, irq;
  logic        por, bor, pin_n;
  logic [3:0]  ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, n_compared, t1, ta;

  rcs_sequencer #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER), .OST_CYCLES(8)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .POR_EVENT(por), .BOR_EVENT(bor),
    .EXT_RESET_PIN_N(pin_n), .EXT_RESET_SELECT(sel), .POWERUP_TIMER_CFG(cfg),
    .WATCHDOG_EXPIRE(ev[0]), .WATCHDOG_CLEAR_INSTR(ev[1]), .SLEEP_INSTR(ev[2]),
    .IRQ_WAKE(ev[3]), .GLOBAL_IRQ_ENABLE(global_irq_enable), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(err), .CORE_RUN(run), .CORE_RESET_N(crst_n), .IRQ(irq));
  rcs_supply_model sup (.clk(clk), .por_event(por), .bor_event(bor), .ext_reset_pin_n(pin_n));

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    se = err;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask : rdchk

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
  endtask : pulse

  // bounded so a core that never starts still ends the test
  task automatic wait_run(input logic want);
    int n;
    n = 0;
    while (run !== want && n < 400)
    begin
      @(posedge clk);
      t1++;
      n++;
    end
    chk("core run", want, run);
  endtask : wait_run

  task automatic boot(input logic brown);
    t1 = 0;
    sup.supply(brown);
    wait_run(1'b0);
    wait_run(1'b1);
  endtask : boot

  task automatic note(input string s);
    $display("test %s done, errors %0d", s, n_errors);
  endtask : note

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    {rst_n, sel, cfg, global_irq_enable, psel, penable, pwrite} = 7'b0100000;
    ev = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    n_compared = 0;
    t1 = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h18);
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, `RCS_ADDR_PWRCTL, 32'hFFFFFFFF);
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h3);
    boot(1'b0);
    ta = t1;
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h1);
    cfg <= 1'b1;
    boot(1'b0);
    chk("timer span", POWERUP_TIMER, ta - t1);
    note("power_up");
    apb(1'b1, `RCS_ADDR_PWRCTL, 32'h3);
    boot(1'b1);
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h2);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h18);
    note("brown_out");
    sup.pin(1'b0);
    sup.supply(1'b0);
    repeat (60) @(posedge clk);
    chk("held by pin", 0, run);
    sup.pin(1'b1);
    t1 = 0;
    wait_run(1'b1);
    chk("late pin start", 1, t1 <= 5);
    sel <= 1'b0;
    sup.pin(1'b0);
    boot(1'b0);
    sup.pin(1'b1);
    // let the synchroniser see the high pin before selecting it
    repeat (3) @(posedge clk);
    sel <= 1'b1;
    note("pin_start");
    apb(1'b1, `RCS_ADDR_PWRCTL, 32'h3);
    apb(1'b1, `RCS_ADDR_IRQ_EN, 32'h4);
    pulse(4'h3);
    repeat (4) @(posedge clk);
    chk("cleared in time", 1, run);
    pulse(4'h1);
    wait_run(1'b0);
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h08);
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h3);
    @(posedge clk);
    chk("irq raised", 1, irq);
    apb(1'b1, `RCS_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    apb(1'b1, `RCS_ADDR_IRQ_CLR, 32'h3F);
    rdchk("irq status", `RCS_ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    note("watchdog");
    sup.pin(1'b0);
    repeat (6) @(posedge clk);
    sup.pin(1'b1);
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h08);
    rdchk("power_control_flags", `RCS_ADDR_PWRCTL, 32'hFFFFFFFF, 32'h3);
    pulse(4'h4);
    repeat (3) @(posedge clk);
    chk("asleep", 1, {run, crst_n});
    pulse(4'h1);
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h00);
    global_irq_enable <= 1'b1;
    pulse(4'h4);
    pulse(4'h8);
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h10);
    rdchk("pc", `RCS_ADDR_PC, 32'hFFFFFFFF, 32'h4);
    global_irq_enable <= 1'b0;
    pulse(4'h4);
    sup.pin(1'b0);
    repeat (6) @(posedge clk);
    sup.pin(1'b1);
    wait_run(1'b1);
    rdchk("status", `RCS_ADDR_STATUS, 32'hF8, 32'h10);
    note("sleep");
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", 1, se);
    chk("unmapped data", 0, rd);
    note("unmapped");
    give_verdict();
  end
endmodule : tb_top
